// file: common/mmd_pkg.sv
// Constants and types for the memory map and mode decoder.
// Assumes a single 20 MHz clock domain; all address figures are physical byte addresses.
package mmd_pkg;

	typedef enum logic [2:0] {
		MMD_TGT_NONE = 3'b000,
		MMD_TGT_ROM = 3'b001,
		MMD_TGT_RAM = 3'b010,
		MMD_TGT_PIO = 3'b011,
		MMD_TGT_EXT = 3'b100,
		MMD_TGT_BAD = 3'b101
	} mmd_tgt_type;

	typedef enum logic [1:0] {
		MMD_MODE_NONE = 2'b00,
		MMD_MODE_NORMAL = 2'b01,
		MMD_MODE_FLASH = 2'b10,
		MMD_MODE_BAD = 2'b11
	} mmd_mode_type;

	typedef enum logic [1:0] {
		MMD_SEQ_IDLE = 2'b00,
		MMD_SEQ_LOW = 2'b01,
		MMD_SEQ_HIGH = 2'b10
	} mmd_seq_type;

	localparam logic [1:0] MMD_SIZE_BYTE = 2'h0;
	localparam logic [1:0] MMD_SIZE_HALF = 2'h1;
	localparam logic [1:0] MMD_SIZE_WORD = 2'h2;

	localparam int MMD_PHYS_BITS = 26;
	localparam int MMD_EXT_BITS = 16;
	localparam int MMD_PIO_BITS = 12;
	localparam logic [25:0] MMD_ROM_REGION_END = 26'h00FFFFF;
	localparam logic [25:0] MMD_EXT_END = 26'h0FFFFFF;
	localparam logic [25:0] MMD_RSV_BASE = 26'h3FF0000;
	localparam logic [25:0] MMD_RAM_TOP = 26'h3FFEFFF;
	localparam logic [25:0] MMD_PIO_BASE = 26'h3FFF000;
	localparam logic [31:0] MMD_RESET_ENTRY = 32'h00000000;
	localparam logic [25:0] MMD_KB = 26'h0000400;
	localparam logic [1:0] MMD_STRAP_SETTLE = 2'h3;
	localparam logic [MMD_PIO_BITS-1:0] MMD_PIO_HALF_STEP = 12'h002;

endpackage

// file: logic/mmd_strap_sync.sv
// Three-stage synchroniser with agreement filter for the mode straps.
// Assumes straps are static pins driven from outside the clock domain.
`timescale 1ns/1ps
module mmd_strap_sync
	import mmd_pkg::*;
#(
	parameter int WIDTH = 2
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o,
	output logic settled_o
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [1:0] fill_q;

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			level_o <= '0;
		end else if (s2_q == s3_q) begin
			level_o <= s3_q;
		end
	end

	// Pipeline is meaningful only after it has been filled from the pins
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fill_q <= '0;
		end else if (fill_q != MMD_STRAP_SETTLE) begin
			fill_q <= fill_q + 2'h1;
		end
	end

	// Settled waits for the filtered level to catch up, else a stale zero is taken
	assign settled_o = (fill_q == MMD_STRAP_SETTLE) && (s2_q == s3_q) && (level_o == s3_q);

	fill_bound_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(settled_o) |-> fill_q == MMD_STRAP_SETTLE && level_o == s3_q)
		else $error("Strap settle flagged before pipeline filled");
endmodule

// file: logic/mmd_decoder.sv
// Address map decoder, peripheral width splitter and boot mode selector.
// Assumes a CPU bus master on the same clock and a peripheral bus with ready.
// Operation
// - Primary strap low gives normal; high with secondary low gives flash; both high barred
// - Normal mode: bus pins in port mode, fetch starts at ROM reset entry
// - Data accesses ignore address bits 31 to 26; 64 images of 64 MB
// - Program counter upper 6 bits are zero; only 26 bits address fetches
// - Fetches and reads in lowest 1 MB go to ROM; writes go external
// - Smallest variant: 128 KB ROM; rest of ROM region prohibited
// - Mid variants: 256 KB ROM; rest of ROM region prohibited
// - Largest variant: 512 KB ROM; rest of ROM region prohibited
// - 8 KB RAM at 03FFD000 to 03FFEFFF; below it prohibited
// - 16 KB RAM at 03FFB000 to 03FFEFFF; below it prohibited
// - 32 KB RAM at 03FF7000 to 03FFEFFF; below it prohibited
// - 4 KB window 03FFF000 to 03FFFFFF goes to peripheral registers
// - No instruction fetch from the peripheral area
// - Peripheral word access becomes low then high halfword, low 2 bits ignored
// - Halfword to byte register: upper read byte undefined, only lower byte written
// - External accesses use 16 address lines; a 64 KB image repeats
// - Operand address carry beyond 32 bits is dropped; space wraps
// - No prefetch from RAM top may cross into the peripheral area
`timescale 1ns/1ps
module mmd_decoder
	import mmd_pkg::*;
#(
	parameter int ROM_KB = 256,
	parameter int RAM_KB = 16,
	parameter bit EXT_ENABLE = 1'b1
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic mode_strap_primary_i,
	input wire logic mode_strap_secondary_i,
	output mmd_mode_type mode_o,
	output logic mode_valid_o,
	output logic port_mode_o,
	output logic cpu_run_o,
	output logic [31:0] reset_entry_o,
	input wire logic req_valid_i,
	input wire logic req_fetch_i,
	input wire logic req_write_i,
	input wire logic [1:0] req_size_i,
	input wire logic [31:0] req_base_i,
	input wire logic [15:0] req_disp_i,
	input wire logic [31:0] req_pc_i,
	input wire logic [31:0] req_wdata_i,
	output logic req_ready_o,
	input wire logic pf_req_i,
	input wire logic [31:0] pf_pc_i,
	output logic pf_grant_o,
	output logic rsp_valid_o,
	output mmd_tgt_type rsp_tgt_o,
	output logic [31:0] rsp_addr_o,
	output logic [31:0] rsp_rdata_o,
	output logic [MMD_EXT_BITS-1:0] ext_muxed_addr_lines_o,
	output logic pio_valid_o,
	output logic pio_write_o,
	output logic [MMD_PIO_BITS-1:0] pio_addr_o,
	output logic [1:0] pio_be_o,
	output logic [15:0] pio_wdata_o,
	input wire logic pio_ready_i,
	input wire logic pio_byte_reg_i,
	input wire logic [15:0] pio_rdata_i
);
	// Sizes derive from the variant; ROM starts at zero, RAM ends below the I/O window
	localparam logic [25:0] ROM_END = 26'(ROM_KB) * MMD_KB - 26'h1;
	localparam logic [25:0] RAM_BASE = MMD_PIO_BASE - 26'(RAM_KB) * MMD_KB;

	logic [1:0] strap_lvl;
	logic strap_ok;
	logic mode_lock_q;
	logic [31:0] oper_addr;
	logic [25:0] phys;
	mmd_tgt_type tgt;
	mmd_seq_type seq_q;
	logic word_q;
	logic write_q;
	logic [15:0] hi_wdata_q;
	logic [15:0] lo_rdata_q;
	logic is_pio;
	logic [1:0] pio_be_q;

	mmd_strap_sync #(.WIDTH(2)) u_strap (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.pin_i({mode_strap_secondary_i, mode_strap_primary_i}),
		.level_o(strap_lvl),
		.settled_o(strap_ok)
	);

	function automatic mmd_mode_type strap_mode(input logic [1:0] lvl);
		if (!lvl[0]) begin
			strap_mode = MMD_MODE_NORMAL;
		end else if (!lvl[1]) begin
			strap_mode = MMD_MODE_FLASH;
		end else begin
			strap_mode = MMD_MODE_BAD;
		end
	endfunction

	// Region decode, shared by the access path and the prefetch guard
	function automatic mmd_tgt_type decode(input logic [25:0] a, input logic fetch,
		input logic wr);
		if (a <= MMD_ROM_REGION_END) begin
			if (wr && !fetch) begin
				decode = EXT_ENABLE ? MMD_TGT_EXT : MMD_TGT_BAD;
			end else if (a <= ROM_END) begin
				decode = MMD_TGT_ROM;
			end else begin
				decode = MMD_TGT_BAD;
			end
		end else if (a <= MMD_EXT_END) begin
			decode = EXT_ENABLE ? MMD_TGT_EXT : MMD_TGT_BAD;
		end else if (a >= MMD_PIO_BASE) begin
			decode = fetch ? MMD_TGT_BAD : MMD_TGT_PIO;
		end else if (a >= RAM_BASE && a <= MMD_RAM_TOP) begin
			decode = MMD_TGT_RAM;
		end else begin
			decode = MMD_TGT_BAD;
		end
	endfunction

	// Straps are taken once; later pin changes, such as a port driving the
	// primary strap for self-programming, cannot disturb the running mode
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_lock_q <= 1'b0;
			mode_o <= MMD_MODE_NONE;
		end else if (!mode_lock_q && strap_ok) begin
			mode_lock_q <= 1'b1;
			mode_o <= strap_mode(strap_lvl);
		end
	end

	assign mode_valid_o = mode_lock_q;
	assign cpu_run_o = mode_lock_q && (mode_o == MMD_MODE_NORMAL);
	assign reset_entry_o = MMD_RESET_ENTRY;

	// Bus pins stay in port mode from reset; nothing in this block reconfigures them later
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			port_mode_o <= 1'b1;
		end
	end

	// The 32-bit sum drops its carry, so the top and bottom of the space meet
	assign oper_addr = req_base_i + {{16{req_disp_i[15]}}, req_disp_i};
	assign phys = req_fetch_i ? req_pc_i[25:0] : oper_addr[25:0];
	assign tgt = decode(phys, req_fetch_i, req_write_i);
	assign is_pio = (tgt == MMD_TGT_PIO);
	assign req_ready_o = cpu_run_o && (seq_q == MMD_SEQ_IDLE);

	// Prefetch is refused if the following fetch would land in the I/O window
	assign pf_grant_o = pf_req_i && cpu_run_o &&
		(decode(pf_pc_i[25:0], 1'b1, 1'b0) != MMD_TGT_BAD);

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rsp_tgt_o <= MMD_TGT_NONE;
			rsp_addr_o <= '0;
			ext_muxed_addr_lines_o <= '0;
		end else if (req_valid_i && req_ready_o) begin
			rsp_tgt_o <= tgt;
			rsp_addr_o <= {6'h00, phys};
			ext_muxed_addr_lines_o <= phys[MMD_EXT_BITS-1:0];
		end
	end

	// Peripheral sequencer: one halfword or byte per step, words in two steps
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			seq_q <= MMD_SEQ_IDLE;
		end else begin
			case (seq_q)
				MMD_SEQ_IDLE: begin
					if (req_valid_i && req_ready_o && is_pio) begin
						seq_q <= MMD_SEQ_LOW;
					end
				end
				MMD_SEQ_LOW: begin
					if (pio_ready_i) begin
						seq_q <= word_q ? MMD_SEQ_HIGH : MMD_SEQ_IDLE;
					end
				end
				MMD_SEQ_HIGH: begin
					if (pio_ready_i) begin
						seq_q <= MMD_SEQ_IDLE;
					end
				end
				default: begin
					seq_q <= MMD_SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			word_q <= 1'b0;
			write_q <= 1'b0;
			pio_addr_o <= '0;
			pio_be_q <= 2'h0;
			pio_wdata_o <= '0;
			hi_wdata_q <= '0;
		end else if (seq_q == MMD_SEQ_IDLE && req_valid_i && req_ready_o && is_pio) begin
			word_q <= (req_size_i == MMD_SIZE_WORD);
			write_q <= req_write_i;
			hi_wdata_q <= req_wdata_i[31:16];
			if (req_size_i == MMD_SIZE_BYTE) begin
				pio_addr_o <= phys[MMD_PIO_BITS-1:0];
				pio_be_q <= phys[0] ? 2'h2 : 2'h1;
				pio_wdata_o <= phys[0] ? {req_wdata_i[7:0], 8'h00} : req_wdata_i[15:0];
			end else begin
				pio_addr_o <= {phys[MMD_PIO_BITS-1:2], 2'h0};
				pio_be_q <= 2'h3;
				pio_wdata_o <= req_wdata_i[15:0];
			end
			if (req_size_i == MMD_SIZE_HALF) begin
				pio_addr_o <= {phys[MMD_PIO_BITS-1:1], 1'b0};
			end
		end else if (seq_q == MMD_SEQ_LOW && pio_ready_i && word_q) begin
			pio_addr_o <= pio_addr_o + MMD_PIO_HALF_STEP;
			pio_wdata_o <= hi_wdata_q;
		end
	end

	assign pio_valid_o = (seq_q != MMD_SEQ_IDLE);
	assign pio_write_o = write_q;

	// Byte-wide registers hear only the low lane on a wide write
	always_comb begin
		pio_be_o = pio_be_q;
		if (pio_byte_reg_i && pio_be_q == 2'h3) begin
			pio_be_o = 2'h1;
		end
	end

	function automatic logic [15:0] lane_fix(input logic [15:0] d, input logic byte_reg);
		lane_fix = byte_reg ? {8'h00, d[7:0]} : d;
	endfunction

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lo_rdata_q <= '0;
			rsp_rdata_o <= '0;
			rsp_valid_o <= 1'b0;
		end else begin
			rsp_valid_o <= 1'b0;
			if (seq_q == MMD_SEQ_IDLE && req_valid_i && req_ready_o && !is_pio) begin
				rsp_valid_o <= 1'b1;
				rsp_rdata_o <= '0;
			end else if (seq_q == MMD_SEQ_LOW && pio_ready_i) begin
				lo_rdata_q <= lane_fix(pio_rdata_i, pio_byte_reg_i);
				if (!word_q) begin
					rsp_valid_o <= 1'b1;
					rsp_rdata_o <= {16'h0000, lane_fix(pio_rdata_i, pio_byte_reg_i)};
				end
			end else if (seq_q == MMD_SEQ_HIGH && pio_ready_i) begin
				rsp_valid_o <= 1'b1;
				rsp_rdata_o <= {lane_fix(pio_rdata_i, pio_byte_reg_i), lo_rdata_q};
			end
		end
	end

	mode_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		mode_valid_o |=> mode_valid_o && $stable(mode_o))
		else $error("Operating mode changed after being taken");

	mode_normal_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(mode_valid_o) && !$past(strap_lvl[0]) |-> mode_o == MMD_MODE_NORMAL)
		else $error("Low primary strap did not give normal mode");

	run_port_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		cpu_run_o |-> port_mode_o && reset_entry_o == MMD_RESET_ENTRY)
		else $error("Normal mode start without port mode or reset entry");

	alias_addr_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_ready_o |=> rsp_addr_o[31:26] == 6'h00)
		else $error("Upper address bits leaked into decoded address");

	pio_nofetch_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_ready_o && req_fetch_i |=> rsp_tgt_o != MMD_TGT_PIO)
		else $error("Instruction fetch routed to peripheral area");

	rom_write_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_ready_o && req_write_i && !req_fetch_i
		&& phys <= MMD_ROM_REGION_END |=> rsp_tgt_o != MMD_TGT_ROM)
		else $error("Data write routed to internal ROM");

	ext_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_ready_o |=> ext_muxed_addr_lines_o == rsp_addr_o[15:0])
		else $error("External lines do not carry the 64 KB image");

	word_split_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		seq_q == MMD_SEQ_LOW && pio_ready_i && word_q |=>
		seq_q == MMD_SEQ_HIGH && pio_addr_o[1:0] == 2'h2)
		else $error("Word access did not continue with upper half");

	pf_guard_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		pf_req_i && pf_pc_i[25:0] >= MMD_PIO_BASE |-> !pf_grant_o)
		else $error("Prefetch granted into peripheral area");

	byte_lane_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		pio_valid_o && pio_byte_reg_i && pio_be_q == 2'h3 |-> pio_be_o == 2'h1)
		else $error("Wide write reached upper lane of byte register");
endmodule

// file: verif/mmd_pio_model.sv
// Peripheral register responder beyond the decoder's peripheral bus.
// Assumes one clock; the bench picks ready latency and register width.
`timescale 1ns/1ps
module mmd_pio_model (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [1:0] lat_i,
	input wire logic byte_reg_i,
	input wire logic pio_valid_i,
	input wire logic [11:0] pio_addr_i,
	output logic pio_ready_o,
	output logic pio_byte_reg_o,
	output logic [15:0] pio_rdata_o
);
	logic [1:0] wait_q;
	assign pio_byte_reg_o = byte_reg_i;
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wait_q <= 2'h0;
			pio_ready_o <= 1'b0;
			pio_rdata_o <= 16'h0;
		end else if (pio_ready_o) begin
			// Data turns over after ready so a late sample cannot match
			pio_ready_o <= 1'b0;
			pio_rdata_o <= ~pio_rdata_o;
			wait_q <= 2'h0;
		end else if (pio_valid_i && wait_q == lat_i) begin
			pio_ready_o <= 1'b1;
			pio_rdata_o <= {4'hC, pio_addr_i};
		end else if (pio_valid_i) begin
			wait_q <= wait_q + 2'h1;
		end
	end
endmodule

// file: verif/memory_map_mode_decoder_test.sv
// Self-checking bench for the memory map and mode decoder.
// Assumes the peripheral responder model; the bench plays the CPU master.
`timescale 1ns/1ps
module memory_map_mode_decoder_test
	import mmd_pkg::*;
;
	localparam int ROM = 256;
	localparam int RAM = 16;
	logic clk = 1'b0, rst_n = 1'b0, sp = 1'b0, ss = 1'b0, rv = 1'b0, rf = 1'b0, rw = 1'b0;
	logic pfr = 1'b0, bya = 1'b0;
	logic [1:0] rs = 2'h0, lat = 2'h0;
	logic [31:0] rb = 32'h0, rpc = 32'h0, wd = 32'h0, pfpc = 32'h0, lf = 32'h19;
	logic [15:0] rd = 16'h0;
	mmd_mode_type mode;
	mmd_tgt_type tgt;
	logic mv, pm, run, rdy, pfg, rsv, pv, pwr, prdy, pbyte;
	logic [31:0] entry, raddr, rdat;
	logic [15:0] ext, pwd, prd;
	logic [11:0] pa;
	logic [1:0] pbe;
	int err_count = 0, compares = 0, cyc = 0, k;
	logic [11:0] qa[$];
	logic [15:0] qw[$];
	logic [2:0] qb[$];
	logic [25:0] rgn[4] = '{26'h0, 26'h100000, 26'h3FF0000, 26'h1000000};
	// Random RAM-side offsets stop short of the peripheral window
	logic [25:0] msk[4] = '{26'hFFFFF, 26'hFFFFF, 26'hEFFF, 26'hFFFFF};
	mmd_decoder #(.ROM_KB(ROM), .RAM_KB(RAM), .EXT_ENABLE(1'b1)) dut (.ref_clk_i(clk),
		.reset_n_i(rst_n), .mode_strap_primary_i(sp), .mode_strap_secondary_i(ss),
		.mode_o(mode), .mode_valid_o(mv), .port_mode_o(pm), .cpu_run_o(run),
		.reset_entry_o(entry), .req_valid_i(rv), .req_fetch_i(rf), .req_write_i(rw),
		.req_size_i(rs), .req_base_i(rb), .req_disp_i(rd), .req_pc_i(rpc),
		.req_wdata_i(wd), .req_ready_o(rdy), .pf_req_i(pfr), .pf_pc_i(pfpc),
		.pf_grant_o(pfg), .rsp_valid_o(rsv), .rsp_tgt_o(tgt), .rsp_addr_o(raddr),
		.rsp_rdata_o(rdat), .ext_muxed_addr_lines_o(ext), .pio_valid_o(pv),
		.pio_write_o(pwr), .pio_addr_o(pa), .pio_be_o(pbe), .pio_wdata_o(pwd),
		.pio_ready_i(prdy), .pio_byte_reg_i(pbyte), .pio_rdata_i(prd));
	mmd_pio_model peer (.ref_clk_i(clk), .reset_n_i(rst_n), .lat_i(lat), .byte_reg_i(bya),
		.pio_valid_i(pv), .pio_addr_i(pa), .pio_ready_o(prdy), .pio_byte_reg_o(pbyte),
		.pio_rdata_o(prd));
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		if (pv === 1'b1 && prdy === 1'b1) begin
			qa.push_back(pa);
			qw.push_back(pwd);
			qb.push_back({pwr, pbe});
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic mmd_tgt_type exp_tgt(input logic f, w, input logic [25:0] p);
		if (p <= MMD_ROM_REGION_END)
			return (w && !f) ? MMD_TGT_EXT : (p < ROM * 1024) ? MMD_TGT_ROM : MMD_TGT_BAD;
		if (p <= MMD_EXT_END) return MMD_TGT_EXT;
		if (p < MMD_RSV_BASE) return MMD_TGT_BAD;
		if (p < MMD_PIO_BASE) return (p >= MMD_PIO_BASE - RAM * 1024) ? MMD_TGT_RAM : MMD_TGT_BAD;
		return f ? MMD_TGT_BAD : MMD_TGT_PIO;
	endfunction
	function automatic mmd_mode_type exp_mode(input logic p, s);
		return !p ? MMD_MODE_NORMAL : !s ? MMD_MODE_FLASH : MMD_MODE_BAD;
	endfunction
	function automatic logic [15:0] half(input logic [11:0] a, input logic b);
		return b ? {8'h00, a[7:0]} : {4'hC, a};
	endfunction
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic boot(input logic p, s);
		int n;
		rst_n = 1'b0;
		sp = p;
		ss = s;
		repeat (6) @(posedge clk);
		chk_val(pm, 1'b1);
		#1 rst_n = 1'b1;
		n = 0;
		while (mv !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		chk_val(mode, exp_mode(p, s));
		chk_val(run, !p);
		chk_val(entry, MMD_RESET_ENTRY);
		// Software raising the primary strap later must not disturb the mode
		sp = 1'b1;
		ss = !s;
		repeat (8) @(posedge clk);
		#1 chk_val(mode, exp_mode(p, s));
		chk_val({rdy, pm}, {!p, 1'b1});
	endtask
	task automatic acc(input logic f, w, input logic [1:0] s, input logic [31:0] b,
		input logic [15:0] d, input logic [31:0] v, output int n);
		@(posedge clk);
		#1 {rf, rw, rs, rd, wd, rpc} = {f, w, s, d, v, b};
		// Base is scrambled on fetches so only the program counter can decide
		rb = f ? ~b : b;
		rv = 1'b1;
		n = 0;
		while (rdy !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1 n++;
		end
		@(posedge clk);
		#1 rv = 1'b0;
		n = 0;
		while (rsv !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	task automatic one(input logic f, w, input logic [31:0] b, input logic [15:0] d);
		int n;
		logic [31:0] sum;
		sum = b + {{16{d[15]}}, d};
		acc(f, w, MMD_SIZE_WORD, b, d, 32'h0, n);
		if (!f) b = sum;
		chk_val(n, 0);
		chk_val(tgt, exp_tgt(f, w, b[25:0]));
		chk_val(raddr, {6'h0, b[25:0]});
		if (exp_tgt(f, w, b[25:0]) == MMD_TGT_EXT) chk_val(ext, b[15:0]);
	endtask
	task automatic pio(input logic w, input logic [1:0] s, input logic [11:0] a, input logic b,
		input logic [1:0] l);
		int n;
		logic [11:0] a0;
		lat = l;
		bya = b;
		qa.delete();
		qw.delete();
		qb.delete();
		lf = lfsr(lf);
		acc(1'b0, w, s, {lf[31:26], MMD_PIO_BASE[25:12], a}, 16'h0, lf, n);
		a0 = (s == MMD_SIZE_WORD) ? (a & 12'hFFC) : a;
		chk_val({tgt, n < 50}, {MMD_TGT_PIO, 1'b1});
		chk_val(qa.size(), (s == MMD_SIZE_WORD) ? 2 : 1);
		chk_val(qa[0], a0);
		chk_val(qb[0], {w, b ? 2'h1 : 2'h3});
		if (s == MMD_SIZE_WORD) chk_val(qa[1], a0 + MMD_PIO_HALF_STEP);
		if (w) chk_val(qw[0], lf[15:0]);
		if (w && s == MMD_SIZE_WORD) chk_val(qw[1], lf[31:16]);
		if (!w && s == MMD_SIZE_WORD) chk_val(rdat, {half(a0 + 12'h002, b), half(a0, b)});
		if (!w && s != MMD_SIZE_WORD) chk_val(rdat[15:0], half(a0, b));
	endtask
	task automatic pf(input logic [31:0] v, input logic e);
		@(posedge clk);
		#1 pfpc = v;
		pfr = 1'b1;
		#1 chk_val(pfg, e);
	endtask
	initial begin
		boot(1'b1, 1'b1);
		boot(1'b1, 1'b0);
		boot(1'b0, 1'b1);
		boot(1'b0, 1'b0);
		one(1'b1, 1'b0, 32'hFC000000, 16'h0);
		one(1'b0, 1'b0, 32'h0003FFFF, 16'h0);
		one(1'b0, 1'b0, 32'h00040000, 16'h0);
		one(1'b1, 1'b0, 32'h000FFFFF, 16'h0);
		one(1'b0, 1'b1, 32'h00000010, 16'h0);
		one(1'b0, 1'b0, 32'h00123456, 16'h0);
		one(1'b0, 1'b0, 32'h00FFFFFF, 16'h0);
		one(1'b0, 1'b0, 32'h01000000, 16'h0);
		one(1'b0, 1'b0, 32'h03FFAFFF, 16'h0);
		one(1'b1, 1'b0, 32'h03FFB000, 16'h0);
		one(1'b0, 1'b1, 32'hC3FFEFFF, 16'h0);
		one(1'b1, 1'b0, 32'h03FFF000, 16'h0);
		one(1'b0, 1'b0, 32'hFFFFFFF0, 16'h0020);
		one(1'b0, 1'b0, 32'h00000000, 16'h8000);
		// Only defined register offsets are used in the peripheral window
		pio(1'b0, MMD_SIZE_WORD, 12'h006, 1'b0, 2'h0);
		pio(1'b1, MMD_SIZE_WORD, 12'h027, 1'b0, 2'h3);
		pio(1'b0, MMD_SIZE_WORD, 12'h100, 1'b1, 2'h2);
		pio(1'b0, MMD_SIZE_HALF, 12'h110, 1'b1, 2'h1);
		pio(1'b1, MMD_SIZE_HALF, 12'h024, 1'b1, 2'h0);
		pf(32'h03FFEFFC, 1'b1);
		pf(32'h03FFF000, 1'b0);
		pf(32'h00000000, 1'b1);
		for (int i = 0; i < 40; i++) begin
			lf = lfsr(lf);
			k = lf[1:0];
			one(lf[2], lf[3] & ~lf[2], {lf[31:26], rgn[k] + (26'(lf[29:10]) & msk[k])}, 16'h0);
		end
		tally_and_finish();
	end
endmodule
